// ---- logic/adc_ctrl_pkg.sv ----
// constants shared by the sigma-delta converter control block
package adc_ctrl_pkg;
    // register byte offsets
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_POWER  = 8'h04;
    localparam logic [7:0] OFS_EXC    = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_DATA   = 8'h10;
    // config register fields
    localparam int RANGE_LSB = 0;
    localparam int RANGE_W   = 3;
    localparam int UNI_BIT   = 3;
    localparam int CHAN_LSB  = 4;
    localparam int CHAN_W    = 3;
    localparam int SF_LSB    = 8;
    localparam int SF_W      = 8;
    // power register fields
    localparam int PWR_BIT  = 0;
    localparam int KEEP_BIT = 1;
    // excitation register fields
    localparam int NUM_SRC = 3;
    localparam int EN_LSB  = 0;
    localparam int SEL_LSB = 4;
    // status register bits
    localparam int ST_RDY    = 0;
    localparam int ST_LOCK   = 1;
    localparam int ST_OSC    = 2;
    localparam int ST_SETTLE = 3;
    // reset values
    localparam logic [2:0] RANGE_RST = 3'h0;
    localparam logic       UNI_RST   = 1'h1;
    localparam logic [2:0] CHAN_RST  = 3'h0;
    localparam logic [7:0] SF_RST    = 8'h44;
    localparam logic       PWR_RST   = 1'h1;
    localparam logic       KEEP_RST  = 1'h0;
    // source currents in microamps
    localparam logic [9:0] I_A_UA = 10'h0c8;
    localparam logic [9:0] I_B_UA = 10'h0c8;
    localparam logic [9:0] I_C_UA = 10'h019;
    // clocking
    localparam longint CLK_HZ   = 100_000_000;
    localparam longint XTAL_HZ  = 32_768;
    localparam longint OP_HZ    = 4_194_304;
    localparam int     PLL_MULT = int'(OP_HZ / XTAL_HZ);
    localparam logic [31:0] NCO_INC = 32'((OP_HZ << 32) / CLK_HZ);
    localparam int     OSC_START_MS  = 300;
    localparam int     OSC_START_CYC = int'(OSC_START_MS * (CLK_HZ / 1000));
    // filter timing in modulator samples
    localparam logic [4:0] SAMPLES_PER_SF = 5'h18;
    localparam logic [7:0] SF_MIN         = 8'h0d;
    localparam logic [1:0] SETTLE_CONV    = 2'h3;
    // output coding
    localparam int              SAMPLE_W  = 24;
    localparam int              CODE_W    = 16;
    localparam int              UNI_SHIFT = 7;
    localparam int              BIP_SHIFT = 8;
    localparam logic signed [31:0] CODE_MID = 32'sh0000_8000;
    localparam logic signed [31:0] CODE_MAX = 32'sh0000_ffff;
    localparam logic [2:0]      HSIZE_WORD = 3'h2;
    // oscillator and power state, gray along off-start-run
    typedef enum logic [1:0] {
        OSC_OFF   = 2'b00,
        OSC_START = 2'b01,
        OSC_RUN   = 2'b11,
        OSC_HOLD  = 2'b10
    } osc_state_t;
endpackage

// ---- logic/adc_ctrl.sv ----
// control, clocking and result coding around a 16-bit sigma-delta channel
// Contract
// - eight gain ranges, 20 mV to 2.56 V full scale, unipolar or bipolar
// - gain is 1 on widest range, 128 on narrowest, powers of two between
// - polarity bit changes only the output coding, not the signal path
// - unipolar coding is straight binary from zeros to all ones
// - unipolar code is input times gain times 2^16 over 1.024 Vref
// - bipolar coding is offset binary, zero input gives midscale
// - bipolar code is 2^15 times one plus input times gain over 1.024 Vref
// - three enabled sources: two of 200 uA, one of 25 uA
// - each source steers to either pin; totals 400, 225 or 425 uA possible
// - pll locks to crystal multiple giving a 4.194304 MHz operating clock
// - the modulator samples at the crystal rate
// - keep-alive bit keeps oscillator running in power-down, no 300 ms wait
// - reset clears logic, filter, modulator and all registers to defaults
// - during reset ready output is high and register accesses are ignored
// - writing 0 to power-up bit powers down, keeping registers and result
// - power-down keeps the bus working but forces ready output high
// - filter rate word ffh gives slowest update rate of 5.35 Hz
// - new result sets ready flag, mirrored low on ready output
// - no valid result after channel change until filter has settled
`timescale 1ns/1ns
module adc_ctrl #(
    parameter int unsigned OSC_START_CYCLES = adc_ctrl_pkg::OSC_START_CYC
) (
    // clock and reset
    input  wire  logic                             mclk,
    input  wire  logic                             rst_n,
    // ahb-lite slave
    input  wire  logic                             hsel,
    input  wire  logic [adc_ctrl_pkg::ADDR_W-1:0]  haddr,
    input  wire  logic [1:0]                       htrans,
    input  wire  logic                             hwrite,
    input  wire  logic [2:0]                       hsize,
    input  wire  logic [31:0]                      hwdata,
    input  wire  logic                             hready,
    output logic       [31:0]                      hrdata,
    output logic                                   hreadyout,
    output logic                                   hresp,
    // crystal and modulator
    input  wire  logic                             xtal_in,
    input  wire  logic signed [adc_ctrl_pkg::SAMPLE_W-1:0] mod_sample,
    output logic                                   osc_en,
    output logic                                   mod_en,
    output logic                                   pll_lock,
    output logic                                   op_tick,
    // analogue front-end controls
    output logic       [7:0]                       gain,
    output logic       [adc_ctrl_pkg::CHAN_W-1:0]  channel,
    output logic       [adc_ctrl_pkg::NUM_SRC-1:0] current_src_en,
    output logic       [adc_ctrl_pkg::NUM_SRC-1:0] current_src_to_b,
    output logic       [9:0]                       current_pin_a,
    output logic       [9:0]                       current_pin_b,
    // result and ready
    output logic       [adc_ctrl_pkg::CODE_W-1:0]  result,
    output logic                                   ready_n
);
    import adc_ctrl_pkg::*;

    // scale, code and clamp one filtered sample
    function automatic logic [CODE_W-1:0] code_calc(
        input logic signed [SAMPLE_W-1:0] s,
        input logic [RANGE_W-1:0] rng,
        input logic polarity_select
    );
        logic signed [31:0] p;
        logic signed [31:0] c;
        p = 32'(s) <<< rng;
        if (polarity_select) begin
            c = p >>> UNI_SHIFT;
        end else begin
            c = (p >>> BIP_SHIFT) + CODE_MID;
        end
        if (c < 0) begin
            code_calc = '0;
        end else if (c > CODE_MAX) begin
            code_calc = '1;
        end else begin
            code_calc = c[CODE_W-1:0];
        end
    endfunction

    logic       [RANGE_W-1:0] range_q;
    logic                     uni_q;
    logic       [SF_W-1:0]    sf_q;
    logic                     pwr_q;
    logic                     keep_q;
    logic                     wr_q;
    logic                     rd_q;
    logic       [ADDR_W-1:0]  addr_q;
    logic                     rdy_q;
    logic       [1:0]         settle_q;
    logic       [12:0]        samp_q;
    logic       [31:0]        nco_q;
    logic       [7:0]         opcnt_q;
    logic       [31:0]        start_q;
    logic       [2:0]         xs_q;
    osc_state_t               st_q;
    logic                     xtal_rise;
    logic                     converting;
    logic                     conv_done;
    logic                     data_rd;
    logic       [12:0]        conv_len;
    logic       [SF_W-1:0]    sf_eff;
    logic       [32:0]        nco_sum;
    logic       [31:0]        rd_word;

    // bus strobes and conversion timing
    assign xtal_rise  = xs_q[1] & ~xs_q[2] & osc_en;
    // no conversion ends once power-down is written, so the result stays put
    assign converting = (st_q == OSC_RUN) & pwr_q & pll_lock;
    assign sf_eff     = (sf_q < SF_MIN) ? SF_MIN : sf_q;
    assign conv_len   = 13'(sf_eff * SAMPLES_PER_SF);
    assign conv_done  = converting & xtal_rise & (samp_q == conv_len - 13'h1);
    assign data_rd    = rd_q & (addr_q == OFS_DATA);
    assign nco_sum    = {1'b0, nco_q} + {1'b0, NCO_INC};

    // ahb-lite address and data phase tracking, one wait state on reads
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
            addr_q    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= '0;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (rd_q) begin
                hrdata    <= rd_word;
                hreadyout <= 1'b1;
            end
            if (hsel && htrans[1] && hready) begin
                addr_q <= haddr;
                wr_q   <= hwrite && (hsize == HSIZE_WORD);
                rd_q   <= !hwrite;
                if (!hwrite) begin
                    hreadyout <= 1'b0;
                end
            end
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        rd_word = '0;
        unique case (addr_q)
            OFS_CONFIG: begin
                rd_word[RANGE_LSB +: RANGE_W] = range_q;
                rd_word[UNI_BIT]              = uni_q;
                rd_word[CHAN_LSB +: CHAN_W]   = channel;
                rd_word[SF_LSB +: SF_W]       = sf_q;
            end
            OFS_POWER: begin
                rd_word[PWR_BIT]  = pwr_q;
                rd_word[KEEP_BIT] = keep_q;
            end
            OFS_EXC: begin
                rd_word[EN_LSB +: NUM_SRC]  = current_src_en;
                rd_word[SEL_LSB +: NUM_SRC] = current_src_to_b;
            end
            OFS_STATUS: begin
                rd_word[ST_RDY]    = rdy_q;
                rd_word[ST_LOCK]   = pll_lock;
                rd_word[ST_OSC]    = (st_q == OSC_RUN) | (st_q == OSC_HOLD);
                rd_word[ST_SETTLE] = (settle_q != 2'h0);
            end
            OFS_DATA: rd_word[CODE_W-1:0] = result;
            default: rd_word = '0;
        endcase
    end

    // configuration registers, all return to defaults in reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            range_q          <= RANGE_RST;
            uni_q            <= UNI_RST;
            channel          <= CHAN_RST;
            sf_q             <= SF_RST;
            pwr_q            <= PWR_RST;
            keep_q           <= KEEP_RST;
            current_src_en   <= '0;
            current_src_to_b <= '0;
        end else if (wr_q) begin
            unique case (addr_q)
                OFS_CONFIG: begin
                    range_q <= hwdata[RANGE_LSB +: RANGE_W];
                    uni_q   <= hwdata[UNI_BIT];
                    channel <= hwdata[CHAN_LSB +: CHAN_W];
                    sf_q    <= hwdata[SF_LSB +: SF_W];
                end
                OFS_POWER: begin
                    pwr_q  <= hwdata[PWR_BIT];
                    keep_q <= hwdata[KEEP_BIT];
                end
                OFS_EXC: begin
                    current_src_en   <= hwdata[EN_LSB +: NUM_SRC];
                    current_src_to_b <= hwdata[SEL_LSB +: NUM_SRC];
                end
                default: ;
            endcase
        end
    end

    // gain and pin current totals
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gain          <= 8'h01;
            current_pin_a <= '0;
            current_pin_b <= '0;
        end else begin
            gain <= 8'(9'h001 << range_q);
            current_pin_a <=
                (current_src_en[0] & ~current_src_to_b[0] ? I_A_UA : 10'h000) +
                (current_src_en[1] & ~current_src_to_b[1] ? I_B_UA : 10'h000) +
                (current_src_en[2] & ~current_src_to_b[2] ? I_C_UA : 10'h000);
            current_pin_b <=
                (current_src_en[0] & current_src_to_b[0] ? I_A_UA : 10'h000) +
                (current_src_en[1] & current_src_to_b[1] ? I_B_UA : 10'h000) +
                (current_src_en[2] & current_src_to_b[2] ? I_C_UA : 10'h000);
        end
    end

    // crystal pin synchroniser and edge detect
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            xs_q <= '0;
        end else begin
            xs_q <= {xs_q[1:0], xtal_in};
        end
    end

    // oscillator power state with start-up wait
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q    <= OSC_OFF;
            start_q <= '0;
            osc_en  <= 1'b0;
            mod_en  <= 1'b0;
        end else begin
            osc_en <= pwr_q | keep_q | (st_q == OSC_HOLD);
            mod_en <= converting;
            unique case (st_q)
                OSC_OFF: begin
                    start_q <= '0;
                    if (pwr_q) st_q <= OSC_START;
                end
                OSC_START: begin
                    start_q <= start_q + 32'h1;
                    if (!pwr_q && !keep_q) begin
                        st_q <= OSC_OFF;
                    end else if (start_q >= OSC_START_CYCLES - 1) begin
                        st_q <= pwr_q ? OSC_RUN : OSC_HOLD;
                    end
                end
                OSC_RUN: begin
                    if (!pwr_q) st_q <= keep_q ? OSC_HOLD : OSC_OFF;
                end
                OSC_HOLD: begin
                    if (pwr_q) begin
                        st_q <= OSC_RUN;
                    end else if (!keep_q) begin
                        st_q <= OSC_OFF;
                    end
                end
            endcase
        end
    end

    // operating clock synthesis and lock check against the crystal
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            nco_q    <= '0;
            op_tick  <= 1'b0;
            opcnt_q  <= '0;
            pll_lock <= 1'b0;
        end else begin
            nco_q   <= nco_sum[31:0];
            op_tick <= nco_sum[32];
            if (st_q == OSC_OFF || st_q == OSC_START) begin
                opcnt_q  <= '0;
                pll_lock <= 1'b0;
            end else if (xtal_rise) begin
                opcnt_q  <= '0;
                pll_lock <= (opcnt_q >= 8'(PLL_MULT - 1))
                          && (opcnt_q <= 8'(PLL_MULT + 1));
            end else if (nco_sum[32] && opcnt_q != 8'hff) begin
                opcnt_q <= opcnt_q + 8'h01;
            end
        end
    end

    // decimation count at crystal rate, settling after channel change
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            samp_q   <= '0;
            settle_q <= SETTLE_CONV;
        end else begin
            if (!converting) begin
                samp_q <= '0;
            end else if (xtal_rise) begin
                samp_q <= conv_done ? 13'h0 : samp_q + 13'h1;
            end
            if (wr_q && addr_q == OFS_CONFIG && hwdata[CHAN_LSB +: CHAN_W] != channel) begin
                settle_q <= SETTLE_CONV;
                samp_q   <= '0;
            end else if (conv_done && settle_q != 2'h0) begin
                settle_q <= settle_q - 2'h1;
            end
        end
    end

    // result word and ready flag; a new result beats a data read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            result <= '0;
            rdy_q  <= 1'b0;
        end else begin
            if (conv_done && settle_q == 2'h0) begin
                result <= code_calc(mod_sample, range_q, uni_q);
                rdy_q  <= 1'b1;
            end else if (data_rd) begin
                rdy_q <= 1'b0;
            end
        end
    end

    // ready pin, held high in reset and power-down
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ready_n <= 1'b1;
        end else begin
            ready_n <= ~(rdy_q & pwr_q);
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_rdy_reset_high: assert property (disable iff (1'b0)
        !rst_n |=> ready_n) else $error("ready low after reset cycle");
    a_rdy_pd_high: assert property (
        !pwr_q |=> ready_n) else $error("ready low in power-down");
    a_rdy_mirror: assert property (
        $rose(rdy_q) && pwr_q |=> !ready_n) else $error("ready pin missed flag");
    a_pd_keeps_data: assert property (
        !pwr_q && $past(!pwr_q) |-> $stable(result)) else $error("result changed in power-down");
    a_keep_osc_on: assert property (
        keep_q && !pwr_q |=> osc_en) else $error("oscillator stopped with keep-alive");
    a_gain_step: assert property (
        $stable(range_q) [*2] |-> gain == 8'(9'h001 << range_q)) else $error("gain mismatch");
    a_settle_hold: assert property (
        conv_done && settle_q != 2'h0 |=> $stable(result) && !$rose(rdy_q))
        else $error("result during settling");
    a_count_xtal: assert property (
        converting && $past(converting) && samp_q != $past(samp_q) && samp_q != 13'h0
        |-> $past(xtal_rise)) else $error("sample count off crystal edge");
    a_clamp_low: assert property (
        conv_done && settle_q == 2'h0 && uni_q && mod_sample < 0 |=> result == '0)
        else $error("negative input not clamped");
    a_pin_total: assert property (
        ($stable(current_src_en) && $stable(current_src_to_b)) [*2]
        |-> current_pin_a + current_pin_b ==
            (current_src_en[0] ? I_A_UA : 10'h000) + (current_src_en[1] ? I_B_UA : 10'h000)
            + (current_src_en[2] ? I_C_UA : 10'h000)) else $error("pin currents wrong");

    c_new_result: cover property ($fell(ready_n));
    c_pd_hold: cover property (st_q == OSC_RUN ##1 st_q == OSC_HOLD);
    c_settle_done: cover property (conv_done && settle_q == 2'h1);
endmodule // adc_ctrl

// ---- verification/ahb_host.sv ----
// bus master standing in for the host microcontroller
`timescale 1ns/1ns
module ahb_host (
    // clock
    input  wire logic                            mclk,
    // ahb-lite master side
    input  wire logic                            hready,
    input  wire logic [31:0]                     hrdata,
    output logic                                 hsel,
    output logic      [adc_ctrl_pkg::ADDR_W-1:0] haddr,
    output logic      [1:0]                      htrans,
    output logic                                 hwrite,
    output logic      [2:0]                      hsize,
    output logic      [31:0]                     hwdata
);
    import adc_ctrl_pkg::*;

    // idle bus at time zero
    initial begin
        hsel   = 1'b0;
        haddr  = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = HSIZE_WORD;
        hwdata = '0;
    end

    // one single word transfer, held until hready is seen at an edge
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= HSIZE_WORD;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        haddr  <= ~a;                  // released address shows no stale value
        hwdata <= wr ? wd : ~hwdata;   // read phase: data lines carry junk
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask
endmodule // ahb_host

// ---- verification/sigma_delta_adc_core_control_bench.sv ----
// register-level bench for the converter control block
`timescale 1ns/1ns
module sigma_delta_adc_core_control_bench;
    import adc_ctrl_pkg::*;
    localparam int CYCLE_LIMIT = 40000;

    logic                          mclk, rst_n, xtal_in;
    logic signed [SAMPLE_W-1:0]    mod_sample;
    logic                          hsel, hwrite, hreadyout, hresp;
    logic        [ADDR_W-1:0]      haddr;
    logic        [1:0]             htrans;
    logic        [2:0]             hsize;
    logic        [31:0]            hwdata, hrdata, rv;
    logic                          osc_en, mod_en, pll_lock, op_tick, ready_n;
    logic        [7:0]             gain;
    logic        [CHAN_W-1:0]      channel;
    logic        [NUM_SRC-1:0]     current_src_en, current_src_to_b;
    logic        [9:0]             current_pin_a, current_pin_b;
    logic        [CODE_W-1:0]      result;
    int                            n_errors, compares, cycles, xcnt, ticks, t0;
    logic        [2:0]             t_en [5] = '{3'h3, 3'h5, 3'h7, 3'h5, 3'h6};
    logic        [2:0]             t_sel[5] = '{3'h0, 3'h0, 3'h7, 3'h4, 3'h3};
    logic        [9:0]             t_a  [5] = '{10'h190, 10'h0e1, 10'h000, 10'h0c8, 10'h019};
    logic        [9:0]             t_b  [5] = '{10'h000, 10'h000, 10'h1a9, 10'h019, 10'h0c8};

    // clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // crystal near 32.768 kHz, still while the oscillator is disabled
    always @(posedge mclk) begin
        xcnt <= (xcnt == 1525) ? 0 : xcnt + 1;
        if (osc_en !== 1'b1) xtal_in <= 1'b0;
        else if (xcnt == 1525) xtal_in <= ~xtal_in;
    end

    // hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            n_errors++;
            final_report();
        end
    end

    always @(posedge mclk) if (op_tick === 1'b1) ticks <= ticks + 1;

    ahb_host host_u (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    adc_ctrl #(.OSC_START_CYCLES(20)) dut_u (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .xtal_in(xtal_in), .mod_sample(mod_sample), .osc_en(osc_en), .mod_en(mod_en),
        .pll_lock(pll_lock), .op_tick(op_tick), .gain(gain), .channel(channel),
        .current_src_en(current_src_en), .current_src_to_b(current_src_to_b),
        .current_pin_a(current_pin_a), .current_pin_b(current_pin_b),
        .result(result), .ready_n(ready_n));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        host_u.xfer(1'b1, a, d, dummy);
    endtask

    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
                          input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] d;
        host_u.xfer(1'b0, a, 32'h0, d);
        check(what, d & mask, exp);
    endtask

    task automatic wait_lock();
        int n;
        n = 0;
        while (pll_lock !== 1'b1 && n < 20000) begin
            @(posedge mclk);
            n++;
        end
    endtask

    // reset phase: a write is issued while reset is low
    task automatic reset_phase();
        rst_n <= 1'b0;
        wr(OFS_CONFIG, 32'h0000_1137);
        check("ready_n in reset", ready_n, 1'b1);
        check("osc_en in reset", osc_en, 1'b0);
        check("gain in reset", gain, 8'h01);
        @(posedge mclk) rst_n <= 1'b1;
        rd_chk("config default", OFS_CONFIG, 32'hffff_ffff, 32'h0000_4408);
        rd_chk("power default", OFS_POWER, 32'hffff_ffff, 32'h0000_0001);
        rd_chk("exc default", OFS_EXC, 32'hffff_ffff, 32'h0000_0000);
        rd_chk("data default", OFS_DATA, 32'hffff_ffff, 32'h0000_0000);
    endtask

    task automatic final_report();
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        xtal_in = 1'b0;
        mod_sample = 24'sh10_0000;
        {n_errors, compares, cycles, xcnt, ticks} = '0;
        reset_phase();
        check("hresp", hresp, 1'b0);
        // every range with alternating coding, then the other coding
        for (int r = 0; r < 8; r++) begin
            wr(OFS_CONFIG, {16'h0, 8'hff, 4'h0, r[0], 3'(r)});
            repeat (2) @(posedge mclk);
            check("gain", gain, 8'h01 << r);
            rd_chk("config", OFS_CONFIG, 32'hffff_ffff, {16'h0, 8'hff, 4'h0, r[0], 3'(r)});
            wr(OFS_CONFIG, {16'h0, 8'hff, 4'h0, ~r[0], 3'(r)});
            repeat (2) @(posedge mclk);
            check("gain after polarity", gain, 8'h01 << r);
            check("channel after polarity", channel, 3'h0);
        end
        // current source enables and steering
        for (int i = 0; i < 5; i++) begin
            wr(OFS_EXC, {25'h0, t_sel[i], 1'b0, t_en[i]});
            repeat (2) @(posedge mclk);
            check("src_en", current_src_en, t_en[i]);
            check("src_to_b", current_src_to_b, t_sel[i]);
            check("pin_a", current_pin_a, t_a[i]);
            check("pin_b", current_pin_b, t_b[i]);
        end
        rd_chk("exc", OFS_EXC, 32'hffff_ffff, 32'h0000_0036);
        // clock synthesis
        wait_lock();
        check("pll_lock", pll_lock, 1'b1);
        rd_chk("status lock", OFS_STATUS, 32'h0000_000f, 32'h0000_000e);
        check("mod_en", mod_en, 1'b1);
        t0 = ticks;
        repeat (1000) @(posedge mclk);
        check("op_tick rate", (ticks - t0) inside {[41:42]}, 1'b1);
        // power-down with the oscillator kept alive
        wr(OFS_POWER, 32'h0000_0002);
        repeat (2) @(posedge mclk);
        check("ready_n down", ready_n, 1'b1);
        check("osc kept", osc_en, 1'b1);
        check("mod_en down", mod_en, 1'b0);
        rd_chk("config kept", OFS_CONFIG, 32'hffff_ffff, 32'h0000_ff07);
        rd_chk("data kept", OFS_DATA, 32'hffff_ffff, 32'h0000_0000);
        wr(OFS_POWER, 32'h0000_0001);
        rd_chk("osc running at wake", OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
        // full power-down: oscillator stops, restart wait on wake
        wr(OFS_POWER, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        check("osc stopped", osc_en, 1'b0);
        check("ready_n off", ready_n, 1'b1);
        wr(OFS_POWER, 32'h0000_0001);
        rd_chk("osc restarting", OFS_STATUS, 32'h0000_0004, 32'h0000_0000);
        wait_lock();
        check("relock", pll_lock, 1'b1);
        // unmapped and read-only places
        rd_chk("unmapped", 8'h14, 32'hffff_ffff, 32'h0000_0000);
        wr(OFS_STATUS, 32'hffff_fff0);
        rd_chk("status ro", OFS_STATUS, 32'h0000_0007, 32'h0000_0006);
        // second reset in mid-run, then reprogramming
        reset_phase();
        wr(OFS_CONFIG, 32'h0000_4403);
        repeat (2) @(posedge mclk);
        check("gain reprogrammed", gain, 8'h08);
        final_report();
    end
endmodule // sigma_delta_adc_core_control_bench
